// file: core/twm_monitor.sv
// What this block does
// - The two hysteresis straps select 1, 2, 5 or 10 degrees of hysteresis.
// - The alarm goes high when a conversion lies outside the low or high trip point.
// - A raised alarm clears only once the reading is inside the window by the hysteresis.
// - The trip window is a constant pair chosen by the product variant parameter.
// - A high force input drives the alarm high three clock cycles later, regardless of temperature.
// - A low force input leaves the alarm to the temperature comparison alone.
// - The alarm is high from power-up until the first conversion finds the reading inside the window by the hysteresis.
// - The first conversion comes 20 to 35 ms after power good and never before it.
// - Later results come every 0.985 to 1 s, so while the force input is low the alarm changes at most once a period.
// - There is one mode only and the thresholds cannot be changed at run time.
`timescale 1ns/1ps

module twm_monitor #(
	parameter twm_pkg::twm_variant_t VARIANT    = twm_pkg::TWM_VAR_A,
	parameter int unsigned           FIRST_CYC  = twm_pkg::FIRST_CONV_CYC,
	parameter int unsigned           PERIOD_CYC = twm_pkg::PERIOD_CYC
) (
	// Clock and reset
	input  wire logic                             i_clk,
	input  wire logic                             i_rst_n,
	// Supply monitor and sensor
	input  wire logic                             i_power_good,
	input  wire logic signed [twm_pkg::TEMP_W-1:0] i_temp_code,
	// Straps and test pin
	input  wire logic                             i_hyst_strap_lo,
	input  wire logic                             i_hyst_strap_hi,
	input  wire logic                             i_force_alarm_high,
	// Outputs
	output logic                                  o_alarm,
	output logic                                  o_conv_done
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic signed [8:0] hyst_of(input logic hi, input logic lo);
		unique case ({hi, lo})
			2'b00:   hyst_of = twm_pkg::HYST_00;
			2'b01:   hyst_of = twm_pkg::HYST_01;
			2'b10:   hyst_of = twm_pkg::HYST_10;
			default: hyst_of = twm_pkg::HYST_11;
		endcase
	endfunction : hyst_of

	// ----------------------------------------------------------------
	// Fixed trip window
	// ----------------------------------------------------------------
	// Thresholds are elaboration constants, so nothing at run time can move them.
	localparam logic signed [8:0] TRIP_LOW  = (VARIANT == twm_pkg::TWM_VAR_C) ?
		twm_pkg::VAR_C_LOW : (VARIANT == twm_pkg::TWM_VAR_B) ?
		twm_pkg::VAR_B_LOW : twm_pkg::VAR_A_LOW;
	localparam logic signed [8:0] TRIP_HIGH = (VARIANT == twm_pkg::TWM_VAR_C) ?
		twm_pkg::VAR_C_HIGH : (VARIANT == twm_pkg::TWM_VAR_B) ?
		twm_pkg::VAR_B_HIGH : twm_pkg::VAR_A_HIGH;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [3:0] meta_q;
	logic [3:0] sync_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
		end else begin
			meta_q <= {i_power_good, i_force_alarm_high, i_hyst_strap_hi, i_hyst_strap_lo};
			sync_q <= meta_q;
		end
	end

	logic pg_s;
	logic force_s;
	logic strap_hi_s;
	logic strap_lo_s;
	assign pg_s       = sync_q[3];
	assign force_s    = sync_q[2];
	assign strap_hi_s = sync_q[1];
	assign strap_lo_s = sync_q[0];

	// ----------------------------------------------------------------
	// Conversion timebase
	// ----------------------------------------------------------------
	// The timebase is held cleared until power is good.
	logic conv_done;

	twm_timebase #(
		.FIRST_CYC  (FIRST_CYC),
		.PERIOD_CYC (PERIOD_CYC)
	) u_timebase (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_run       (pg_s),
		.o_conv_done (conv_done)
	);

	// ----------------------------------------------------------------
	// Sample the temperature code
	// ----------------------------------------------------------------
	// The sensor code is treated as produced by the same clock, so it is not synchronised.
	logic signed [8:0] hyst;
	logic signed [9:0] low_clear;
	logic signed [9:0] high_clear;
	logic              outside;
	logic              inside_hyst;

	always_comb begin
		hyst        = hyst_of(strap_hi_s, strap_lo_s);
		low_clear   = 10'(TRIP_LOW) + 10'(hyst);
		high_clear  = 10'(TRIP_HIGH) - 10'(hyst);
		outside     = (i_temp_code < TRIP_LOW) || (i_temp_code > TRIP_HIGH);
		inside_hyst = (10'(i_temp_code) >= low_clear) && (10'(i_temp_code) <= high_clear);
	end

	// ----------------------------------------------------------------
	// Alarm state
	// ----------------------------------------------------------------
	logic temp_alarm_q;
	logic temp_alarm_d;
	logic alarm_d;

	always_comb begin
		temp_alarm_d = temp_alarm_q;
		if (conv_done) begin
			if (outside) begin
				temp_alarm_d = 1'b1;
			end else if (inside_hyst) begin
				temp_alarm_d = 1'b0;
			end
		end
		alarm_d = temp_alarm_d | force_s;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			temp_alarm_q <= 1'b1;
			o_alarm      <= 1'b1;
			o_conv_done  <= 1'b0;
		end else begin
			temp_alarm_q <= temp_alarm_d;
			o_alarm      <= alarm_d;
			o_conv_done  <= conv_done;
		end
	end

endmodule : twm_monitor

// file: core/twm_pkg.sv
package twm_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned FIRST_CONV_MS   = 26;
	localparam int unsigned FIRST_MIN_MS    = 20;
	localparam int unsigned FIRST_MAX_MS    = 35;
	localparam int unsigned PERIOD_MIN_US   = 985_000;
	localparam int unsigned PERIOD_MAX_US   = 1_000_000;
	// Cycles per millisecond; 125 MHz divides evenly.
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned FIRST_CONV_CYC  = FIRST_CONV_MS * CYC_PER_MS;
	// Period sits in the middle of the allowed band, rounded down.
	localparam int unsigned PERIOD_CYC      = ((PERIOD_MIN_US + PERIOD_MAX_US) / 2)
		* (CLK_HZ / 1_000_000);

	// ----------------------------------------------------------------
	// Temperature code: signed, whole degrees
	// ----------------------------------------------------------------
	localparam int unsigned TEMP_W = 9;

	// ----------------------------------------------------------------
	// Trip windows per product variant
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TWM_VAR_A,
		TWM_VAR_B,
		TWM_VAR_C
	} twm_variant_t;

	localparam logic signed [8:0] VAR_A_LOW  = 9'sd0;
	localparam logic signed [8:0] VAR_A_HIGH = 9'sd60;
	localparam logic signed [8:0] VAR_B_LOW  = 9'sd0;
	localparam logic signed [8:0] VAR_B_HIGH = 9'sd55;
	localparam logic signed [8:0] VAR_C_LOW  = -9'sd20;
	localparam logic signed [8:0] VAR_C_HIGH = 9'sd60;

	// ----------------------------------------------------------------
	// Hysteresis amounts by strap code {hi, lo}
	// ----------------------------------------------------------------
	localparam logic signed [8:0] HYST_00 = 9'sd1;
	localparam logic signed [8:0] HYST_01 = 9'sd2;
	localparam logic signed [8:0] HYST_10 = 9'sd5;
	localparam logic signed [8:0] HYST_11 = 9'sd10;

endpackage : twm_pkg

// file: core/twm_timebase.sv
`timescale 1ns/1ps

// Conversion timebase: one strobe after the first conversion time, then one per period.
module twm_timebase #(
	parameter int unsigned FIRST_CYC  = twm_pkg::FIRST_CONV_CYC,
	parameter int unsigned PERIOD_CYC = twm_pkg::PERIOD_CYC
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Control
	input  wire logic i_run,
	// Strobe
	output logic      o_conv_done
);

	logic [27:0] cnt_q;
	logic [27:0] cnt_d;
	logic        first_q;
	logic        first_d;
	logic        done_d;

	always_comb begin
		cnt_d   = cnt_q;
		first_d = first_q;
		done_d  = 1'b0;
		if (!i_run) begin
			cnt_d   = '0;
			first_d = 1'b1;
		end else if (cnt_q == 28'(first_q ? FIRST_CYC - 1 : PERIOD_CYC - 1)) begin
			cnt_d   = '0;
			first_d = 1'b0;
			done_d  = 1'b1;
		end else begin
			cnt_d = cnt_q + 28'h0000001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_q       <= '0;
			first_q     <= 1'b1;
			o_conv_done <= 1'b0;
		end else begin
			cnt_q       <= cnt_d;
			first_q     <= first_d;
			o_conv_done <= done_d;
		end
	end

endmodule : twm_timebase

// file: tb/twm_host_model.sv
`timescale 1ns/1ps

module twm_host_model (
	// Pin and result strobe
	input  wire logic i_clk,
	input  wire logic i_alarm,
	input  wire logic i_strobe,
	// Level last read
	output logic      o_level
);
	// A polled input reads once per result, so glitches between results stay unseen.
	always_ff @(posedge i_clk) begin
		if (i_strobe) begin
			o_level <= i_alarm;
		end
	end
endmodule : twm_host_model

// file: tb/twm_monitor_asserts.sv
`timescale 1ns/1ps

module twm_monitor_asserts #(
	parameter twm_pkg::twm_variant_t VARIANT    = twm_pkg::TWM_VAR_A,
	parameter int unsigned           FIRST_CYC  = 20,
	parameter int unsigned           PERIOD_CYC = 50
) (
	input wire logic                              i_clk,
	input wire logic                              i_rst_n,
	input wire logic                              i_power_good,
	input wire logic signed [twm_pkg::TEMP_W-1:0] i_temp_code,
	input wire logic                              i_hyst_strap_lo,
	input wire logic                              i_hyst_strap_hi,
	input wire logic                              i_force_alarm_high,
	input wire logic                              o_alarm,
	input wire logic                              o_conv_done
);
	localparam logic signed [8:0] LO = (VARIANT == twm_pkg::TWM_VAR_C) ? twm_pkg::VAR_C_LOW : 9'sd0;
	localparam logic signed [8:0] HI = (VARIANT == twm_pkg::TWM_VAR_B) ? twm_pkg::VAR_B_HIGH : 9'sd60;
	logic signed [8:0] hy;
	logic [4:0]        fh_q;
	logic              seen_q;
	logic [31:0]       cnt_q;
	// Checks wait out the force synchroniser, so a slow release is not mistaken for a fault.
	wire quiet = ~|fh_q & ~i_force_alarm_high;
	assign hy = i_hyst_strap_hi ? (i_hyst_strap_lo ? 9'sd10 : 9'sd5) : (i_hyst_strap_lo ? 9'sd2 : 9'sd1);
	always_ff @(posedge i_clk) begin
		fh_q   <= i_rst_n ? {fh_q[3:0], i_force_alarm_high} : 5'h00;
		seen_q <= i_rst_n & (seen_q | o_conv_done);
		cnt_q  <= !i_rst_n ? 32'h0 : o_conv_done ? 32'h1 : cnt_q + 32'(i_power_good);
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_TRIP_HI: assert property (o_conv_done && $past(i_temp_code) > HI |-> o_alarm)
		else $error("alarm low above high trip");
	AST_TRIP_LO: assert property (o_conv_done && $past(i_temp_code) < LO |-> o_alarm)
		else $error("alarm low below low trip");
	AST_CLEAR: assert property (o_conv_done && quiet && $past(i_temp_code) >= LO + hy
		&& $past(i_temp_code) <= HI - hy |-> !o_alarm) else $error("alarm not cleared");
	AST_BAND: assert property (o_conv_done && $past(o_alarm) && $past(i_temp_code) >= LO
		&& $past(i_temp_code) < LO + hy |-> o_alarm) else $error("alarm cleared in band");
	AST_FORCE: assert property (i_force_alarm_high [*4] |-> o_alarm)
		else $error("force did not raise alarm");
	AST_QUIET: assert property (!o_conv_done && quiet |-> $stable(o_alarm))
		else $error("alarm moved between results");
	AST_PULSE: assert property (o_conv_done |=> !o_conv_done)
		else $error("result strobe too long");
	AST_PERIOD: assert property (o_conv_done && seen_q |-> cnt_q == PERIOD_CYC)
		else $error("result period wrong");
	AST_FIRST: assert property (o_conv_done && !seen_q |-> cnt_q inside {[FIRST_CYC:FIRST_CYC+4]})
		else $error("first result at wrong time");
	AST_BOOT: assert property (!seen_q && !o_conv_done |-> o_alarm)
		else $error("alarm low before first result");
endmodule : twm_monitor_asserts

bind twm_monitor twm_monitor_asserts #(.VARIANT(VARIANT), .FIRST_CYC(FIRST_CYC),
	.PERIOD_CYC(PERIOD_CYC)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_power_good(i_power_good),
	.i_temp_code(i_temp_code), .i_hyst_strap_lo(i_hyst_strap_lo), .i_hyst_strap_hi(i_hyst_strap_hi),
	.i_force_alarm_high(i_force_alarm_high), .o_alarm(o_alarm), .o_conv_done(o_conv_done));

// file: tb/tb_temp_window_monitor_hyst.sv
`timescale 1ns/1ps

module tb_temp_window_monitor_hyst;
	localparam int unsigned FC = 20;
	localparam int unsigned PC = 50;
	logic i_clk = 1'b0, i_rst_n, i_power_good, s_lo, s_hi, force_hi, o_alarm, o_conv_done, lvl;
	logic signed [twm_pkg::TEMP_W-1:0] temp;
	int errors = 0;
	int checks = 0;
	always #4 i_clk = ~i_clk;
	twm_monitor #(.VARIANT(twm_pkg::TWM_VAR_A), .FIRST_CYC(FC), .PERIOD_CYC(PC)) uut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_power_good(i_power_good), .i_temp_code(temp),
		.i_hyst_strap_lo(s_lo), .i_hyst_strap_hi(s_hi), .i_force_alarm_high(force_hi),
		.o_alarm(o_alarm), .o_conv_done(o_conv_done));
	twm_host_model host (.i_clk(i_clk), .i_alarm(o_alarm), .i_strobe(o_conv_done), .o_level(lvl));
	task automatic finish_test;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string nm, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %b seen %b", nm, exp, got);
		end
	endtask : check
	// Waits for a result, then one more cycle so the controller model has read it.
	task automatic result;
		for (int n = 0; n < FC + PC + 8; n++) begin
			@(negedge i_clk);
			if (o_conv_done === 1'b1) begin
				@(negedge i_clk);
				return;
			end
		end
		errors++;
		finish_test();
	endtask : result
	task automatic step(input int v, input logic exp, input string nm);
		@(posedge i_clk);
		temp <= 9'(v);
		result();
		check(nm, exp, lvl);
	endtask : step
	task automatic t_boot;
		check("alarm at start", 1'b1, o_alarm);
		@(posedge i_clk);
		temp         <= 9'sd30;
		i_power_good <= 1'b1;
		result();
		check("first result", 1'b0, lvl);
	endtask : t_boot
	task automatic t_trip;
		step(61, 1'b1, "above high");
		step(-1, 1'b1, "below low");
		step(30, 1'b0, "inside");
		@(posedge i_clk);
		temp <= 9'sd70;
		repeat (5) @(posedge i_clk);
		temp <= 9'sd30;
		result();
		check("between results", 1'b0, lvl);
	endtask : t_trip
	task automatic t_hyst;
		int h[4] = '{1, 2, 5, 10};
		for (int c = 0; c < 4; c++) begin
			@(posedge i_clk);
			{s_hi, s_lo} <= 2'(c);
			step(61, 1'b1, "trip high");
			step(61 - h[c], 1'b1, "high band");
			step(60 - h[c], 1'b0, "high clear");
			step(-1, 1'b1, "trip low");
			step(h[c] - 1, 1'b1, "low band");
			step(h[c], 1'b0, "low clear");
		end
	endtask : t_hyst
	task automatic t_force;
		@(posedge i_clk);
		force_hi <= 1'b1;
		repeat (5) @(negedge i_clk);
		check("forced", 1'b1, o_alarm);
		result();
		check("forced read", 1'b1, lvl);
		@(posedge i_clk);
		force_hi <= 1'b0;
		repeat (5) @(negedge i_clk);
		check("released", 1'b0, o_alarm);
	endtask : t_force
	initial begin
		{i_rst_n, i_power_good, s_lo, s_hi, force_hi, temp} = '0;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(negedge i_clk);
		t_boot();
		t_trip();
		t_hyst();
		t_force();
		finish_test();
	end
endmodule : tb_temp_window_monitor_hyst
